//--- bench/alups_seq_model.sv
`timescale 1ns/10ps
`include "alups_consts.svh"

module alups_seq_model (
   // clock and reset
   input  wire logic        clock_i,
   input  wire logic        nrst_i,
   // request from bench
   input  wire logic        issue_i,
   input  wire logic        cond_i,
   input  wire logic [4:0]  tag_i,
   input  wire logic        dest_i,
   input  wire logic [4:0]  op_i,
   input  wire logic [1:0]  ysel_i,
   input  wire logic [2:0]  xsel_i,
   // to alu
   output logic             instr_valid_o,
   output logic [23:0]      instr_o,
   output logic             cond_true_o
);
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         instr_valid_o <= 1'b0;
         instr_o       <= 24'h000000;
         cond_true_o   <= 1'b0;
      end else begin
         instr_valid_o <= issue_i;
         // idle word toggles so a stale word is never mistaken for a new one
         instr_o       <= issue_i ? {tag_i, dest_i, op_i, ysel_i, xsel_i, 8'h00} : ~instr_o;
         cond_true_o   <= issue_i ? cond_i : ~cond_true_o;
      end
   end
endmodule : alups_seq_model

//--- bench/alups_top_assertions.sv
`timescale 1ns/10ps
`include "alups_consts.svh"

module alups_chk
   import alups_pkg::*;
#(
   parameter int DW = `ALUPS_DATA_W
) (
   // clock and reset
   input wire logic                     clock_i,
   input wire logic                     nrst_i,
   // apb
   input wire logic                     psel_i,
   input wire logic                     penable_i,
   input wire logic                     pwrite_i,
   // instruction and operands
   input wire logic                     instr_valid_i,
   input wire logic [`ALUPS_INSTR_W-1:0] instr_i,
   input wire logic                     cond_true_i,
   input wire logic [DW-1:0]            mult_result_low_i,
   input wire logic [DW-1:0]            mult_result_mid_i,
   // results
   input wire logic [DW-1:0]            alu_result_reg_o,
   input wire logic [DW-1:0]            alu_feedback_reg_o,
   input wire logic [7:0]               alu_status_word_o,
   input wire logic                     exec_o,
   input wire logic                     reject_o
);
   wire [4:0] op_w    = instr_i[`ALUPS_OP_HI:`ALUPS_OP_LO];
   wire       logic_w = op_w inside {`ALUPS_OP_AND, `ALUPS_OP_OR, `ALUPS_OP_XOR, `ALUPS_OP_PASS_Y,
                                     `ALUPS_OP_PASS_X, `ALUPS_OP_PASS_ONE};
   wire       known_w = logic_w || op_w inside {`ALUPS_OP_SUB_XY, `ALUPS_OP_SBB_XY, `ALUPS_OP_SUB_YX,
                                                `ALUPS_OP_SBB_YX};
   wire       ok_w    = instr_i[23:19] == `ALUPS_TAG_VAL && instr_i[7:4] == 4'h0 && known_w;
   wire       swr_w   = psel_i && penable_i && pwrite_i;

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!nrst_i);

   sequence s_go;
      instr_valid_i && cond_true_i && ok_w;
   endsequence

   a_exec_on_go: assert property (s_go |=> exec_o && !reject_o) else $error("no exec pulse");
   a_skip_on_false: assert property (instr_valid_i && !cond_true_i && !swr_w |=> !exec_o &&
      $stable(alu_result_reg_o) && $stable(alu_feedback_reg_o) && $stable(alu_status_word_o))
      else $error("false condition changed state");
   a_reject_bad: assert property (instr_valid_i && cond_true_i && !ok_w |=> reject_o && !exec_o)
      else $error("bad word not rejected");
   a_zero_flag: assert property (exec_o |-> alu_status_word_o[0] ==
      (($past(instr_i[18]) ? alu_feedback_reg_o : alu_result_reg_o) == '0)) else $error("zero flag wrong");
   a_neg_flag: assert property (exec_o |-> alu_status_word_o[1] ==
      ($past(instr_i[18]) ? alu_feedback_reg_o[DW-1] : alu_result_reg_o[DW-1])) else $error("neg flag wrong");
   a_logic_clear: assert property (s_go ##0 logic_w |=> alu_status_word_o[3:2] == 2'b00)
      else $error("logic op left carry or overflow");
   a_upper_kept: assert property (s_go ##0 !swr_w |=> $stable(alu_status_word_o[7:4]))
      else $error("upper status changed");
   a_dest_pick: assert property (s_go ##0 (!swr_w && !instr_i[18]) |=> $stable(alu_feedback_reg_o))
      else $error("wrong destination written");
   a_sub_xy: assert property (s_go ##0 (op_w == `ALUPS_OP_SUB_XY && !instr_i[18] &&
      instr_i[12:8] == {ALUPS_Y_FEEDBACK, ALUPS_X_MULT_LOW}) |=>
      alu_result_reg_o == $past(mult_result_low_i) - $past(alu_feedback_reg_o) &&
      alu_status_word_o[3] == ($past(mult_result_low_i) >= $past(alu_feedback_reg_o))) else $error("sub wrong");
   a_pass_x: assert property (s_go ##0 (op_w == `ALUPS_OP_PASS_X && !instr_i[18] &&
      instr_i[10:8] == ALUPS_X_MULT_MID) |=> alu_result_reg_o == $past(mult_result_mid_i))
      else $error("pass x wrong");
endmodule : alups_chk

//--- bench/test_alups_top.sv
`timescale 1ns/10ps
`include "alups_consts.svh"
`define CHK(a, b, m) begin comparisons++; if ((a) !== (b)) begin fail_count++; $display("MISMATCH %0t %s", $time, m); end end

module test_alups_top
   import alups_pkg::*;
;
   logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic [3:0]  pstrb = 4'h0;
   logic        pready, pslverr, ivalid, ctrue, exec, rej, e, c;
   logic [23:0] instr;
   logic        issue = 1'b0, cond = 1'b0, dest = 1'b0;
   logic [4:0]  op = 5'h00, tag = `ALUPS_TAG_VAL;
   logic [1:0]  ysel = 2'h0;
   logic [2:0]  xsel = 3'h0;
   logic [15:0] mlo = 16'h1234, mmid = 16'h8000, res, fb, xv, yv;
   logic [15:0] mhi = 16'hA5A5, slo = 16'h00FF, shi = 16'hFFFF;
   logic [7:0]  st;
   logic [19:0] ex;
   logic [4:0]  ops [10] = '{`ALUPS_OP_SUB_XY, `ALUPS_OP_SBB_XY, `ALUPS_OP_SUB_YX, `ALUPS_OP_SBB_YX, `ALUPS_OP_AND,
                             `ALUPS_OP_OR, `ALUPS_OP_XOR, `ALUPS_OP_PASS_Y, `ALUPS_OP_PASS_X, `ALUPS_OP_PASS_ONE};
   int          fail_count = 0, comparisons = 0;

   always #2.5 clk = ~clk;

   alups_seq_model u_seq (.clock_i(clk), .nrst_i(nrst), .issue_i(issue), .cond_i(cond), .tag_i(tag),
      .dest_i(dest), .op_i(op), .ysel_i(ysel), .xsel_i(xsel), .instr_valid_o(ivalid), .instr_o(instr),
      .cond_true_o(ctrue));

   alups_top DUT (.clock_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .instr_valid_i(ivalid), .instr_i(instr), .cond_true_i(ctrue),
      .mult_result_low_i(mlo), .mult_result_mid_i(mmid), .mult_result_high_i(mhi),
      .shift_result_low_i(slo), .shift_result_high_i(shi), .alu_result_reg_o(res),
      .alu_feedback_reg_o(fb), .alu_status_word_o(st), .exec_o(exec), .reject_o(rej));

   task conclude;
      if (fail_count == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : conclude

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; pstrb <= 4'hF;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin fail_count++; conclude(); end
   endtask : apb

   // present one instruction; returns after its executing edge has settled
   task automatic ins(input logic d, input logic [4:0] o, input logic [1:0] y, input logic [2:0] x, input logic cd);
      @(posedge clk);
      issue <= 1'b1; dest <= d; op <= o; ysel <= y; xsel <= x; cond <= cd;
      @(posedge clk);
      issue <= 1'b0;
      @(posedge clk);
      #1;
   endtask : ins

   // returns carry, overflow, negative, zero and result
   function automatic logic [19:0] ref_op(input logic [4:0] o, input logic [15:0] x, y, input logic ci);
      logic [16:0] f;
      logic [15:0] a, b;
      logic        cin, ar;
      ar = 1'b1; a = x; b = y; cin = 1'b1;
      case (o)
         `ALUPS_OP_SUB_XY: ;
         `ALUPS_OP_SBB_XY: cin = ci;
         `ALUPS_OP_SUB_YX: begin a = y; b = x; end
         `ALUPS_OP_SBB_YX: begin a = y; b = x; cin = ci; end
         default: ar = 1'b0;
      endcase
      f = {1'b0, a} + {1'b0, ~b} + {16'h0000, cin};
      if (!ar) begin
         case (o)
            `ALUPS_OP_AND:    f = {1'b0, x & y};
            `ALUPS_OP_OR:     f = {1'b0, x | y};
            `ALUPS_OP_XOR:    f = {1'b0, x ^ y};
            `ALUPS_OP_PASS_Y: f = {1'b0, y};
            `ALUPS_OP_PASS_X: f = {1'b0, x};
            default:          f = {1'b0, `ALUPS_CONST_ONE};
         endcase
      end
      return {ar & f[16], ar & (a[15] != b[15]) & (f[15] != a[15]), f[15], f[15:0] == 16'h0000, f[15:0]};
   endfunction : ref_op

   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      `CHK({res, fb, st}, 40'h0, "reset values")
      apb(1'b1, `ALUPS_OFF_STATUS, 32'h0000_00F8);
      c = 1'b1;
      for (int p = 0; p < 2; p++) begin
         xv = p ? 16'h8000 : 16'h0005;
         yv = p ? 16'h0001 : 16'h0007;
         apb(1'b1, `ALUPS_OFF_X0, {16'h0000, xv});
         apb(1'b1, `ALUPS_OFF_Y0, {16'h0000, yv});
         foreach (ops[i]) begin
            ins(1'b0, ops[i], ALUPS_Y_IN0, ALUPS_X_IN0, 1'b1);
            ex = ref_op(ops[i], xv, yv, c);
            c = ex[19];
            `CHK(exec, 1'b1, "exec pulse")
            `CHK(res, ex[15:0], "result")
            `CHK(st, {4'hF, ex[19:16]}, "status")
         end
      end
      ins(1'b1, `ALUPS_OP_SUB_XY, ALUPS_Y_IN0, ALUPS_X_IN0, 1'b0);
      `CHK({exec, rej, fb}, 18'h0, "false condition")
      ins(1'b1, `ALUPS_OP_SUB_XY, ALUPS_Y_IN0, ALUPS_X_IN0, 1'b1);
      `CHK({fb, res}, 32'h7FFF_0001, "feedback destination")
      apb(1'b0, `ALUPS_OFF_FEEDBACK, 32'h0);
      `CHK(q, 32'h0000_7FFF, "feedback readback")
      @(posedge clk);
      issue <= 1'b1; dest <= 1'b0; op <= `ALUPS_OP_SUB_XY; ysel <= ALUPS_Y_FEEDBACK; xsel <= ALUPS_X_MULT_LOW;
      @(posedge clk);
      op <= `ALUPS_OP_PASS_X;
      xsel <= ALUPS_X_MULT_MID;
      @(posedge clk);
      issue <= 1'b0;
      #1;
      `CHK(res, 16'h9235, "chained subtract")
      @(posedge clk);
      #1;
      `CHK({exec, res}, {1'b1, mmid}, "chained pass")
      apb(1'b1, `ALUPS_OFF_X1, 32'h0000_0123);
      apb(1'b1, `ALUPS_OFF_Y1, 32'h0000_4567);
      ins(1'b0, `ALUPS_OP_PASS_X, ALUPS_Y_IN0, ALUPS_X_IN1, 1'b1);
      `CHK(res, 16'h0123, "x input one")
      ins(1'b1, `ALUPS_OP_PASS_X, ALUPS_Y_IN0, ALUPS_X_RESULT, 1'b1);
      `CHK(fb, 16'h0123, "result as x")
      ins(1'b0, `ALUPS_OP_PASS_Y, ALUPS_Y_IN1, ALUPS_X_IN0, 1'b1);
      `CHK(res, 16'h4567, "y input one")
      for (int k = 3; k < 8; k++) begin
         ins(1'b0, `ALUPS_OP_PASS_X, ALUPS_Y_IN0, 3'(k), 1'b1);
         `CHK(res, (k == 3) ? mlo : (k == 4) ? mmid : (k == 5) ? mhi : (k == 6) ? slo : shi, "x word")
      end
      ins(1'b0, `ALUPS_OP_PASS_Y, ALUPS_Y_ZERO, ALUPS_X_IN0, 1'b1);
      `CHK({res, st}, 24'h0000_F1, "pass zero")
      apb(1'b0, `ALUPS_OFF_RESULT, 32'hFFFF_FFFF);
      `CHK(q, 32'h0, "result readback")
      apb(1'b0, `ALUPS_OFF_STATUS, 32'h0);
      `CHK(q, 32'h0000_00F1, "status readback")
      ins(1'b0, 5'h00, ALUPS_Y_IN0, ALUPS_X_IN1, 1'b1);
      `CHK({rej, exec, res}, 18'h2_0000, "unknown code")
      tag <= 5'b00101;
      ins(1'b0, `ALUPS_OP_PASS_X, ALUPS_Y_IN0, ALUPS_X_IN0, 1'b1);
      `CHK({rej, exec, res}, 18'h2_0000, "bad tag")
      apb(1'b0, 8'h1C, 32'h0);
      `CHK({e, q}, 33'h1_0000_0000, "unmapped read")
      conclude();
   end
endmodule : test_alups_top

bind alups_top alups_chk #(.DW(DW)) u_chk (.clock_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .instr_valid_i,
   .instr_i, .cond_true_i, .mult_result_low_i, .mult_result_mid_i, .alu_result_reg_o, .alu_feedback_reg_o,
   .alu_status_word_o, .exec_o, .reject_o);

//--- verilog/alups_addsub.sv
`timescale 1ns/10ps
`include "alups_consts.svh"

module alups_addsub
   import alups_pkg::*;
#(
   parameter int DW = `ALUPS_DATA_W
) (
   // operands
   input  wire logic [DW-1:0] a_i,
   input  wire logic [DW-1:0] b_i,
   input  wire logic          cin_i,
   // result
   output logic      [DW-1:0] sum_o,
   output logic               cout_o,
   output logic               ovf_o
);

   logic [DW:0] full;

   assign full   = {1'b0, a_i} + {1'b0, b_i} + {{DW{1'b0}}, cin_i};
   assign sum_o  = full[DW-1:0];
   assign cout_o = full[DW];
   // two's complement overflow: like-signed inputs, sum of other sign
   assign ovf_o  = (a_i[DW-1] == b_i[DW-1]) && (full[DW-1] != a_i[DW-1]);

endmodule : alups_addsub

//--- verilog/alups_consts.svh
`ifndef ALUPS_CONSTS_SVH
`define ALUPS_CONSTS_SVH

// data path and instruction word
`define ALUPS_DATA_W        16
`define ALUPS_INSTR_W       24
`define ALUPS_TAG_HI        23
`define ALUPS_TAG_LO        19
`define ALUPS_TAG_VAL       5'b00100
`define ALUPS_DEST_BIT      18
`define ALUPS_OP_HI         17
`define ALUPS_OP_LO         13
`define ALUPS_YSEL_HI       12
`define ALUPS_YSEL_LO       11
`define ALUPS_XSEL_HI       10
`define ALUPS_XSEL_LO       8
`define ALUPS_PAD_HI        7
`define ALUPS_PAD_LO        4

// operation function codes
`define ALUPS_OP_SUB_XY     5'b10111
`define ALUPS_OP_SBB_XY     5'b10110
`define ALUPS_OP_SUB_YX     5'b11001
`define ALUPS_OP_SBB_YX     5'b11010
`define ALUPS_OP_AND        5'b11100
`define ALUPS_OP_OR         5'b11101
`define ALUPS_OP_XOR        5'b11110
`define ALUPS_OP_PASS_Y     5'b10000
`define ALUPS_OP_PASS_X     5'b10011
`define ALUPS_OP_PASS_ONE   5'b10001

// pass constant
`define ALUPS_CONST_ONE     16'h0001

// status word bit positions
`define ALUPS_ST_ZERO       0
`define ALUPS_ST_NEG        1
`define ALUPS_ST_OVF        2
`define ALUPS_ST_CARRY      3

// register byte offsets
`define ALUPS_ADDR_W        8
`define ALUPS_OFF_STATUS    8'h00
`define ALUPS_OFF_X0        8'h04
`define ALUPS_OFF_X1        8'h08
`define ALUPS_OFF_Y0        8'h0C
`define ALUPS_OFF_Y1        8'h10
`define ALUPS_OFF_RESULT    8'h14
`define ALUPS_OFF_FEEDBACK  8'h18

// reset values
`define ALUPS_RST_STATUS    8'h00
`define ALUPS_RST_WORD      16'h0000

`endif

//--- verilog/alups_pkg.sv
`include "alups_consts.svh"

package alups_pkg;

   typedef logic [`ALUPS_DATA_W-1:0]  alups_word_t;
   typedef logic [7:0]                alups_status_t;

   // x operand select codes, in field order
   typedef enum logic [2:0] {
      ALUPS_X_IN0,
      ALUPS_X_IN1,
      ALUPS_X_RESULT,
      ALUPS_X_MULT_LOW,
      ALUPS_X_MULT_MID,
      ALUPS_X_MULT_HIGH,
      ALUPS_X_SHIFT_LOW,
      ALUPS_X_SHIFT_HIGH
   } alups_xsel_t;

   // y operand select codes, in field order
   typedef enum logic [1:0] {
      ALUPS_Y_IN0,
      ALUPS_Y_IN1,
      ALUPS_Y_FEEDBACK,
      ALUPS_Y_ZERO
   } alups_ysel_t;

endpackage : alups_pkg

//--- verilog/alups_top.sv
`timescale 1ns/10ps
`include "alups_consts.svh"

module alups_top
   import alups_pkg::*;
#(
   parameter int DW = `ALUPS_DATA_W
) (
   // clock and reset
   input  wire logic                     clock_i,
   input  wire logic                     nrst_i,
   // apb slave
   input  wire logic                     psel_i,
   input  wire logic                     penable_i,
   input  wire logic                     pwrite_i,
   input  wire logic [`ALUPS_ADDR_W-1:0] paddr_i,
   input  wire logic [31:0]              pwdata_i,
   input  wire logic [3:0]               pstrb_i,
   output logic      [31:0]              prdata_o,
   output logic                          pready_o,
   output logic                          pslverr_o,
   // instruction from decoder
   input  wire logic                     instr_valid_i,
   input  wire logic [`ALUPS_INSTR_W-1:0] instr_i,
   input  wire logic                     cond_true_i,
   // operand words from multiplier and shifter
   input  wire logic [DW-1:0]            mult_result_low_i,
   input  wire logic [DW-1:0]            mult_result_mid_i,
   input  wire logic [DW-1:0]            mult_result_high_i,
   input  wire logic [DW-1:0]            shift_result_low_i,
   input  wire logic [DW-1:0]            shift_result_high_i,
   // results and status
   output logic      [DW-1:0]            alu_result_reg_o,
   output logic      [DW-1:0]            alu_feedback_reg_o,
   output logic      [7:0]               alu_status_word_o,
   output logic                          exec_o,
   output logic                          reject_o
);

   // byte-lane merge for software writes to data words
   function automatic logic [DW-1:0] lane_merge(input logic [DW-1:0] old_v,
                                                input logic [31:0]   wdata,
                                                input logic [3:0]    strb);
      logic [DW-1:0] res;
      res = old_v;
      for (int i = 0; i < DW; i++) begin
         if (strb[i/8]) begin
            res[i] = wdata[i];
         end
      end
      return res;
   endfunction : lane_merge

   function automatic logic [31:0] widen(input logic [DW-1:0] v);
      return {{(32-DW){1'b0}}, v};
   endfunction : widen

   // state
   logic [7:0]    status_ff;
   logic [DW-1:0] result_ff;
   logic [DW-1:0] feedback_ff;
   logic [DW-1:0] x_in0_ff;
   logic [DW-1:0] x_in1_ff;
   logic [DW-1:0] y_in0_ff;
   logic [DW-1:0] y_in1_ff;
   logic [31:0]   prdata_ff;
   logic          pslverr_ff;
   logic          exec_ff;
   logic          reject_ff;

   // instruction fields
   logic          tag_hit;
   logic          instr_hit;
   logic [4:0]    op_code;
   logic          dest_feedback;
   alups_xsel_t   x_sel;
   alups_ysel_t   y_sel;

   assign tag_hit       = instr_i[`ALUPS_TAG_HI:`ALUPS_TAG_LO] == `ALUPS_TAG_VAL;
   assign instr_hit     = instr_valid_i && tag_hit &&
                          (instr_i[`ALUPS_PAD_HI:`ALUPS_PAD_LO] == 4'h0);
   assign op_code       = instr_i[`ALUPS_OP_HI:`ALUPS_OP_LO];
   assign dest_feedback = instr_i[`ALUPS_DEST_BIT];
   assign x_sel         = alups_xsel_t'(instr_i[`ALUPS_XSEL_HI:`ALUPS_XSEL_LO]);
   assign y_sel         = alups_ysel_t'(instr_i[`ALUPS_YSEL_HI:`ALUPS_YSEL_LO]);

   // operand selection
   logic [DW-1:0] x_opnd;
   logic [DW-1:0] y_opnd;

   assign x_opnd = (x_sel == ALUPS_X_IN0)       ? x_in0_ff            :
                   (x_sel == ALUPS_X_IN1)       ? x_in1_ff            :
                   (x_sel == ALUPS_X_RESULT)    ? result_ff           :
                   (x_sel == ALUPS_X_MULT_LOW)  ? mult_result_low_i   :
                   (x_sel == ALUPS_X_MULT_MID)  ? mult_result_mid_i   :
                   (x_sel == ALUPS_X_MULT_HIGH) ? mult_result_high_i  :
                   (x_sel == ALUPS_X_SHIFT_LOW) ? shift_result_low_i  :
                                                  shift_result_high_i;
   // zero source lets pass clear a register
   assign y_opnd = (y_sel == ALUPS_Y_IN0)      ? y_in0_ff    :
                   (y_sel == ALUPS_Y_IN1)      ? y_in1_ff    :
                   (y_sel == ALUPS_Y_FEEDBACK) ? feedback_ff :
                                                 {DW{1'b0}};

   // operation decode
   logic op_sub_xy;
   logic op_sbb_xy;
   logic op_sub_yx;
   logic op_sbb_yx;
   logic op_and;
   logic op_or;
   logic op_xor;
   logic op_pass_y;
   logic op_pass_x;
   logic op_pass_one;
   logic op_sub;
   logic op_borrow;
   logic op_rev;
   logic op_known;
   logic exec_go;

   assign op_sub_xy   = op_code == `ALUPS_OP_SUB_XY;
   assign op_sbb_xy   = op_code == `ALUPS_OP_SBB_XY;
   assign op_sub_yx   = op_code == `ALUPS_OP_SUB_YX;
   assign op_sbb_yx   = op_code == `ALUPS_OP_SBB_YX;
   assign op_and      = op_code == `ALUPS_OP_AND;
   assign op_or       = op_code == `ALUPS_OP_OR;
   assign op_xor      = op_code == `ALUPS_OP_XOR;
   assign op_pass_y   = op_code == `ALUPS_OP_PASS_Y;
   assign op_pass_x   = op_code == `ALUPS_OP_PASS_X;
   assign op_pass_one = op_code == `ALUPS_OP_PASS_ONE;
   assign op_sub      = op_sub_xy || op_sbb_xy || op_sub_yx || op_sbb_yx;
   assign op_borrow   = op_sbb_xy || op_sbb_yx;
   assign op_rev      = op_sub_yx || op_sbb_yx;
   assign op_known    = op_sub || op_and || op_or || op_xor ||
                        op_pass_y || op_pass_x || op_pass_one;
   // single-cycle, never stalls, so it can share a cycle with memory moves
   assign exec_go     = instr_hit && cond_true_i && op_known;

   // subtract as a + ~b + cin; borrow forms feed the carry in
   logic [DW-1:0] add_a;
   logic [DW-1:0] add_b;
   logic          add_cin;
   logic [DW-1:0] add_sum;
   logic          add_cout;
   logic          add_ovf;

   assign add_a   = op_rev ? y_opnd : x_opnd;
   assign add_b   = op_rev ? ~x_opnd : ~y_opnd;
   assign add_cin = op_borrow ? status_ff[`ALUPS_ST_CARRY] : 1'b1;

   alups_addsub #(
      .DW (DW)
   ) u_addsub (
      .a_i    (add_a),
      .b_i    (add_b),
      .cin_i  (add_cin),
      .sum_o  (add_sum),
      .cout_o (add_cout),
      .ovf_o  (add_ovf)
   );

   // result and flags
   logic [DW-1:0] alu_value;
   logic          flag_zero;
   logic          flag_neg;
   logic          flag_ovf;
   logic          flag_carry;

   assign alu_value  = op_sub      ? add_sum          :
                       op_and      ? x_opnd & y_opnd  :
                       op_or       ? x_opnd | y_opnd  :
                       op_xor      ? x_opnd ^ y_opnd  :
                       op_pass_x   ? x_opnd           :
                       op_pass_one ? DW'(`ALUPS_CONST_ONE) :
                                     y_opnd;
   assign flag_zero  = alu_value == {DW{1'b0}};
   assign flag_neg   = alu_value[DW-1];
   assign flag_ovf   = op_sub && add_ovf;
   assign flag_carry = op_sub && add_cout;

   // apb decode
   logic apb_setup;
   logic apb_wr;
   logic hit_status;
   logic hit_x0;
   logic hit_x1;
   logic hit_y0;
   logic hit_y1;
   logic hit_result;
   logic hit_feedback;
   logic addr_mapped;

   assign apb_setup    = psel_i && !penable_i;
   assign apb_wr       = psel_i && penable_i && pwrite_i;
   assign hit_status   = paddr_i == `ALUPS_OFF_STATUS;
   assign hit_x0       = paddr_i == `ALUPS_OFF_X0;
   assign hit_x1       = paddr_i == `ALUPS_OFF_X1;
   assign hit_y0       = paddr_i == `ALUPS_OFF_Y0;
   assign hit_y1       = paddr_i == `ALUPS_OFF_Y1;
   assign hit_result   = paddr_i == `ALUPS_OFF_RESULT;
   assign hit_feedback = paddr_i == `ALUPS_OFF_FEEDBACK;
   assign addr_mapped  = hit_status || hit_x0 || hit_x1 || hit_y0 || hit_y1 ||
                         hit_result || hit_feedback;

   logic [31:0] rd_word;

   assign rd_word = hit_status   ? {24'h000000, status_ff} :
                    hit_x0       ? widen(x_in0_ff)         :
                    hit_x1       ? widen(x_in1_ff)         :
                    hit_y0       ? widen(y_in0_ff)         :
                    hit_y1       ? widen(y_in1_ff)         :
                    hit_result   ? widen(result_ff)        :
                    hit_feedback ? widen(feedback_ff)      :
                                   32'h00000000;

   // next values: software write first, an executing instruction overrides
   logic [7:0]    sw_status;
   logic [7:0]    nxt_status;
   logic [DW-1:0] sw_result;
   logic [DW-1:0] sw_feedback;
   logic [DW-1:0] nxt_result;
   logic [DW-1:0] nxt_feedback;
   logic          wr_result;
   logic          wr_feedback;

   assign sw_status    = (apb_wr && hit_status && pstrb_i[0]) ? pwdata_i[7:0] : status_ff;
   // upper flags belong to other units and are kept
   assign nxt_status   = exec_go ? {sw_status[7:4], flag_carry, flag_ovf, flag_neg, flag_zero} :
                                   sw_status;
   assign sw_result    = (apb_wr && hit_result) ? lane_merge(result_ff, pwdata_i, pstrb_i) : result_ff;
   assign sw_feedback  = (apb_wr && hit_feedback) ? lane_merge(feedback_ff, pwdata_i, pstrb_i) :
                                                    feedback_ff;
   assign wr_result    = exec_go && !dest_feedback;
   assign wr_feedback  = exec_go && dest_feedback;
   assign nxt_result   = wr_result ? alu_value : sw_result;
   assign nxt_feedback = wr_feedback ? alu_value : sw_feedback;

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         status_ff   <= `ALUPS_RST_STATUS;
         result_ff   <= `ALUPS_RST_WORD;
         feedback_ff <= `ALUPS_RST_WORD;
      end else begin
         status_ff   <= nxt_status;
         result_ff   <= nxt_result;
         feedback_ff <= nxt_feedback;
      end
   end

   // software writes to the operand input words
   logic [DW-1:0] nxt_x_in0;
   logic [DW-1:0] nxt_x_in1;
   logic [DW-1:0] nxt_y_in0;
   logic [DW-1:0] nxt_y_in1;

   // upper write lanes fall outside the data words and are dropped
   assign nxt_x_in0 = (apb_wr && hit_x0) ? lane_merge(x_in0_ff, pwdata_i, pstrb_i) : x_in0_ff;
   assign nxt_x_in1 = (apb_wr && hit_x1) ? lane_merge(x_in1_ff, pwdata_i, pstrb_i) : x_in1_ff;
   assign nxt_y_in0 = (apb_wr && hit_y0) ? lane_merge(y_in0_ff, pwdata_i, pstrb_i) : y_in0_ff;
   assign nxt_y_in1 = (apb_wr && hit_y1) ? lane_merge(y_in1_ff, pwdata_i, pstrb_i) : y_in1_ff;

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         x_in0_ff <= `ALUPS_RST_WORD;
         x_in1_ff <= `ALUPS_RST_WORD;
         y_in0_ff <= `ALUPS_RST_WORD;
         y_in1_ff <= `ALUPS_RST_WORD;
      end else begin
         x_in0_ff <= nxt_x_in0;
         x_in1_ff <= nxt_x_in1;
         y_in0_ff <= nxt_y_in0;
         y_in1_ff <= nxt_y_in1;
      end
   end

   // read data and error captured in the setup phase
   logic [31:0]   nxt_prdata;
   logic          nxt_pslverr;

   assign nxt_prdata  = pwrite_i ? 32'h00000000 : rd_word;
   // unmapped offsets answer with an error in the access phase
   assign nxt_pslverr = !addr_mapped;

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         prdata_ff  <= 32'h00000000;
         pslverr_ff <= 1'b0;
      end else if (apb_setup) begin
         prdata_ff  <= nxt_prdata;
         pslverr_ff <= nxt_pslverr;
      end
   end

   // decoder pulses, registered on the deciding edge and held for one cycle
   logic          nxt_exec;
   logic          nxt_reject;

   assign nxt_exec   = exec_go;
   // bad tag, nonzero pad bits or unknown code; a false condition is no reject
   assign nxt_reject = instr_valid_i && !(instr_hit && op_known);

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         exec_ff   <= 1'b0;
         reject_ff <= 1'b0;
      end else begin
         exec_ff   <= nxt_exec;
         reject_ff <= nxt_reject;
      end
   end

   assign prdata_o           = prdata_ff;
   assign pready_o           = 1'b1;
   assign pslverr_o          = pslverr_ff && psel_i && penable_i;
   assign alu_result_reg_o   = result_ff;
   assign alu_feedback_reg_o = feedback_ff;
   assign alu_status_word_o  = status_ff;
   assign exec_o             = exec_ff;
   assign reject_o           = reject_ff;

endmodule : alups_top
